// [verilog/cfg_attr_defines.vh]
// Constants for the configuration register attribute block.
// Assumes inclusion by bare name from the design file.
`ifndef CFG_ATTR_DEFINES_VH
`define CFG_ATTR_DEFINES_VH
// Host I/O port addresses of the pointer register and data window
`define PTR_PORT 16'h0cf8
`define DATA_PORT 16'h0cfc
// Pointer register enable bit position
`define PTR_EN_BIT 31
// Register index field inside the pointer
`define PTR_IDX_HI 7
`define PTR_IDX_LO 2
// Configuration register word indices inside the small space
`define IDX_RO 6'h00
`define IDX_RW 6'h01
`define IDX_W1C 6'h02
`define IDX_LOCK 6'h03
`define IDX_STICKY 6'h04
`define IDX_STRAP 6'h05
`define IDX_RSVD 6'h06
// Fixed default values
`define RO_VALUE 32'h0000_0001
`define RW_DEFAULT 32'h0000_0000
`define LOCK_DEFAULT 32'h0000_0000
`define STICKY_DEFAULT 32'h0000_0000
`define RSVD_VALUE 32'h5a5a_0000
`endif

// [verilog/cfg_attr.v]
// Configuration register bank showing the access attributes of the hub.
// Assumes a host I/O port with byte enables, one access per cycle,
// power-valid and strap pins filtered here, soft reset taken asynchronously.
// What this block does
// - Byte, word and dword accesses all accepted
// - Pointer register taken only as full dword
// - Lowest byte lane holds least significant byte
// - Read-only register ignores writes
// - Read/write register stores and returns data
// - Writing one clears bit; zero keeps it
// - Lock bits take one write per power-up
// - Lockable register writable until locked
// - Sticky register survives soft reset
// - Full reset loads fixed defaults
// - Some defaults captured from straps
// - Reserved location reads nonzero, writes dropped
// - Config reached via pointer and data window
// - Both sets reached through host I/O space
// - Soft reset clears pointer, read/write and W1C registers only
// - Power-valid reset clears all registers but the pin filters, the read answer and ack
`timescale 1ns/100ps
`include "cfg_attr_defines.vh"

module cfg_attr #(
  parameter STRAP_W = 8
) (
  input wire i_mclk,
  input wire i_rst,
  input wire i_soft_reset_input_n,
  input wire i_power_valid_input,
  input wire [STRAP_W-1:0] i_strap,
  input wire i_io_wr,
  input wire i_io_rd,
  input wire [15:0] i_io_addr,
  input wire [3:0] i_io_be,
  input wire [31:0] i_io_wdata,
  input wire [31:0] i_event,
  output reg [31:0] o_io_rdata,
  output reg o_io_ack
);

  ////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  // Power-valid and strap pins come from off-chip, so each passes three
  // flops and a new level is only believed once the last two agree; a
  // single-cycle glitch on a pin therefore never reaches the resets.
  reg pv_s1;
  reg pv_s2;
  reg pv_s3;
  reg pv_ok;
  reg [STRAP_W-1:0] strap_s1;
  reg [STRAP_W-1:0] strap_s2;
  reg [STRAP_W-1:0] strap_s3;
  reg [STRAP_W-1:0] strap_ok;

  // No reset here: the chain must follow the pin even while reset is held
  always @(posedge i_mclk) begin
    pv_s1 <= i_power_valid_input;
    pv_s2 <= pv_s1;
    pv_s3 <= pv_s2;
    if (pv_s2 == pv_s3) begin
      pv_ok <= pv_s3;
    end
  end

  // Strap levels filtered the same way before capture
  always @(posedge i_mclk) begin
    strap_s1 <= i_strap;
    strap_s2 <= strap_s1;
    strap_s3 <= strap_s2;
    if (strap_s2 == strap_s3) begin
      strap_ok <= strap_s3;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Reset combination
  // Hard reset covers the plain reset and a filtered low power-valid;
  // it lags the pin by four clocks, so the host must wait that long
  wire hard_rst = i_rst | ~pv_ok;
  reg strap_take;

  // Merge byte lanes; lane 0 carries the least significant byte
  function [31:0] merge;
    input [31:0] old_v;
    input [31:0] new_v;
    input [3:0] be;
    integer k;
    begin
      merge = old_v;
      for (k = 0; k < 4; k = k + 1) begin
        if (be[k]) begin
          merge[k*8 +: 8] = new_v[k*8 +: 8];
        end
      end
    end
  endfunction

  // Expand byte enables to a bit mask
  function [31:0] lane_mask;
    input [3:0] be;
    begin
      lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    end
  endfunction

  ////////////////////////////////////////////////////////////////////
  // Decode
  wire [15:0] ptr_port = `PTR_PORT;
  wire [15:0] data_port = `DATA_PORT;
  wire ptr_hit = (i_io_addr[15:2] == ptr_port[15:2]);
  wire data_hit = (i_io_addr[15:2] == data_port[15:2]);
  wire full_dw = (i_io_be == 4'hf);
  reg [31:0] ptr;
  wire cfg_on = ptr[`PTR_EN_BIT];
  wire [5:0] idx = ptr[`PTR_IDX_HI:`PTR_IDX_LO];
  wire cfg_wr = i_io_wr & data_hit & cfg_on;
  wire [31:0] wmask = lane_mask(i_io_be);

  reg [31:0] rw_reg;
  reg [31:0] w1c_reg;
  reg [31:0] lock_reg;
  reg lock_done;
  reg [31:0] sticky_reg;
  reg [STRAP_W-1:0] strap_reg;

  ////////////////////////////////////////////////////////////////////
  // Pointer register, soft reset asynchronous
  always @(posedge i_mclk or negedge i_soft_reset_input_n) begin
    if (!i_soft_reset_input_n) begin
      ptr <= 32'h0;
    end else if (hard_rst) begin
      ptr <= 32'h0;
    end else if (i_io_wr & ptr_hit & full_dw) begin
      ptr <= i_io_wdata;
    end
  end

  // Ordinary registers: cleared by either reset
  always @(posedge i_mclk or negedge i_soft_reset_input_n) begin
    if (!i_soft_reset_input_n) begin
      rw_reg <= `RW_DEFAULT;
      w1c_reg <= 32'h0;
    end else if (hard_rst) begin
      rw_reg <= `RW_DEFAULT;
      w1c_reg <= 32'h0;
    end else begin
      if (cfg_wr && idx == `IDX_RW) begin
        rw_reg <= merge(rw_reg, i_io_wdata, i_io_be);
      end
      // Hardware set wins over a clear in the same cycle
      if (cfg_wr && idx == `IDX_W1C) begin
        w1c_reg <= (w1c_reg & ~(i_io_wdata & wmask)) | i_event;
      end else begin
        w1c_reg <= w1c_reg | i_event;
      end
    end
  end

  // Lock and sticky state: only power-up or hard reset clears them
  always @(posedge i_mclk) begin
    if (hard_rst) begin
      lock_reg <= `LOCK_DEFAULT;
      lock_done <= 1'b0;
      sticky_reg <= `STICKY_DEFAULT;
    end else begin
      if (cfg_wr && idx == `IDX_LOCK && !lock_done) begin
        lock_reg <= merge(lock_reg, i_io_wdata, i_io_be);
        lock_done <= 1'b1;
      end
      // Error log keeps its bits across a soft reset
      if (cfg_wr && idx == `IDX_STICKY) begin
        sticky_reg <= (sticky_reg & ~(i_io_wdata & wmask)) | i_event;
      end else begin
        sticky_reg <= sticky_reg | i_event;
      end
    end
  end

  // Strap capture on the first edge after hard reset release
  always @(posedge i_mclk) begin
    if (hard_rst) begin
      strap_take <= 1'b1;
      strap_reg <= {STRAP_W{1'b0}};
    end else if (strap_take) begin
      strap_take <= 1'b0;
      strap_reg <= strap_ok;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Read path; writes to read-only and reserved words are dropped
  reg [31:0] next_rdata;
  always @* begin
    next_rdata = 32'h0;
    if (ptr_hit) begin
      next_rdata = ptr;
    end else if (data_hit && cfg_on) begin
      case (idx)
        `IDX_RO: next_rdata = `RO_VALUE;
        `IDX_RW: next_rdata = rw_reg;
        `IDX_W1C: next_rdata = w1c_reg;
        `IDX_LOCK: next_rdata = lock_reg;
        `IDX_STICKY: next_rdata = sticky_reg;
        `IDX_STRAP: next_rdata = {{(32-STRAP_W){1'b0}}, strap_reg};
        `IDX_RSVD: next_rdata = `RSVD_VALUE;
        default: next_rdata = 32'h0;
      endcase
    end else if (data_hit) begin
      next_rdata = 32'hffff_ffff;
    end
  end

  // Registered answer, one cycle after the request
  // Lanes outside the byte enables read as zero so narrow reads stay clean
  always @(posedge i_mclk) begin
    if (i_rst) begin
      o_io_rdata <= 32'h0;
      o_io_ack <= 1'b0;
    end else begin
      o_io_rdata <= i_io_rd ? (next_rdata & wmask) : 32'h0;
      o_io_ack <= i_io_rd | i_io_wr;
    end
  end

endmodule

// [test/cfg_attr_checker.sv]
// Port assertions for cfg_attr.
// Bound into cfg_attr; keeps its own copy of the pointer.
`timescale 1ns/100ps
module cfg_attr_checker (
  input wire i_mclk,
  input wire i_rst,
  input wire i_soft_reset_input_n,
  input wire i_power_valid_input,
  input wire i_io_wr,
  input wire i_io_rd,
  input wire [15:0] i_io_addr,
  input wire [3:0] i_io_be,
  input wire [31:0] i_io_wdata,
  input wire [31:0] o_io_rdata,
  input wire o_io_ack
);
  reg [31:0] p;
  wire [31:0] q = o_io_rdata;
  wire [6:0] sel = {p[31], p[7:2]};
  wire req = i_io_wr || i_io_rd;
  wire pa = i_io_addr == 16'h0cf8 && i_io_be == 4'hf;
  wire dr = i_io_rd && i_io_addr == 16'h0cfc && i_io_be == 4'hf;
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_rst || !i_power_valid_input);
  // Pointer copy, dropped by any reset
  always @(posedge i_mclk or negedge i_soft_reset_input_n)
    if (!i_soft_reset_input_n || i_rst || !i_power_valid_input) p <= 32'h0;
    else if (i_io_wr && pa) p <= i_io_wdata;
  //////////////////
  chk_ack_sent: assert property (req |=> o_io_ack) else $error("no ack");
  chk_ack_alone: assert property (!req |=> !o_io_ack) else $error("stray ack");
  chk_idle_zero: assert property (!o_io_ack |-> q == 32'h0) else $error("idle");
  chk_lane_mask:
    assert property (i_io_rd && i_io_be == 4'h1 |=> q[31:8] == 24'h0) else $error("lane");
  chk_ro_value: assert property (dr && sel == 7'h40 |=> q == 32'h1) else $error("ro");
  chk_rsvd_value:
    assert property (dr && sel == 7'h46 |=> q == 32'h5a5a0000) else $error("rsvd");
  chk_window_off:
    assert property (dr && !p[31] |=> q == 32'hffffffff) else $error("off");
  chk_ptr_read: assert property (i_io_rd && pa |=> q == p) else $error("ptr");
  cover property (dr && sel == 7'h41);
  cover property (i_io_wr && pa);
  cover property ($fell(i_soft_reset_input_n));
endmodule
bind cfg_attr cfg_attr_checker chk (.*);

// [test/host_model.sv]
// Host processor model issuing single I/O cycles.
// Assumes calls come from one bench process only.
`timescale 1ns/100ps
module host_model (
  input wire i_mclk,
  output reg o_wr,
  output reg o_rd,
  output reg [15:0] o_addr,
  output reg [3:0] o_be,
  output reg [31:0] o_wdata
);
  initial {o_wr, o_rd, o_addr, o_be, o_wdata} = 54'h0;
  // One-cycle request; released data is inverted so stale data never matches
  task io(input w, input [15:0] a, input [3:0] b, input [31:0] d);
    begin
      @(negedge i_mclk);
      {o_wr, o_rd, o_addr, o_be, o_wdata} = {w, !w, a, b, d};
      @(negedge i_mclk);
      {o_wr, o_rd, o_wdata} = {2'b00, ~d};
    end
  endtask
endmodule

// [test/testbench.sv]
// Bench for cfg_attr: table of accesses, then reset and clear cases.
// Drives all I/O through host_model; checker is bound separately.
`timescale 1ns/100ps
module testbench;
  reg i_mclk = 0;
  reg i_rst = 1;
  reg soft_n = 1;
  reg pwr = 1;
  reg [31:0] ev = 32'h0;
  wire wr, rd;
  wire [15:0] ad;
  wire [3:0] be;
  wire [31:0] wd, q;
  wire ack;
  integer failures = 0;
  integer comparisons = 0;
  integer k;
  reg [43:0] rows [0:10];
  host_model host (.i_mclk(i_mclk), .o_wr(wr), .o_rd(rd), .o_addr(ad), .o_be(be), .o_wdata(wd));
  cfg_attr #(.STRAP_W(8)) DUT (.i_mclk(i_mclk), .i_rst(i_rst), .i_soft_reset_input_n(soft_n),
    .i_power_valid_input(pwr), .i_strap(8'hc3), .i_io_wr(wr), .i_io_rd(rd), .i_io_addr(ad),
    .i_io_be(be), .i_io_wdata(wd), .i_event(ev), .o_io_rdata(q), .o_io_ack(ack));
  initial forever #5 i_mclk = ~i_mclk;
  // Whole run needs far less than this
  initial begin
    #20000 failures = failures + 1;
    report_and_stop;
  end
  //////////////////
  task chk(input [79:0] name, input [31:0] seen, input [31:0] exp);
    begin
      comparisons = comparisons + 1;
      if (seen !== exp) begin
        failures = failures + 1;
        $display("wrong value %0s expected %h seen %h", name, exp, seen);
      end
    end
  endtask
  // Pointer is always written whole, so no merge is needed
  task acc(input w, input [3:0] i, input [3:0] b, input [31:0] d);
    begin
      host.io(1'b1, 16'h0cf8, 4'hf, {24'h800000, 2'b00, i, 2'b00});
      host.io(w, 16'h0cfc, b, d);
    end
  endtask
  task report_and_stop;
    begin
      if (failures == 0 && comparisons > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
    end
  endtask
  // Rows: write flag, index, byte enables, data or expected read
  initial begin
    rows = '{44'h00f00000001, 44'h10fffffffff, 44'h00f00000001, 44'h11f12345678,
      44'h01f12345678, 44'h01100000078, 44'h11200005500, 44'h01c12340000,
      44'h01300005578, 44'h06f5a5a0000, 44'h05f000000c3};
    repeat (20) @(negedge i_mclk);
    i_rst = 0;
    for (k = 0; k < 11; k = k + 1) begin
      acc(rows[k][40], rows[k][39:36], rows[k][35:32], rows[k][31:0]);
      chk("o_io_ack", {31'h0, ack}, 32'h1);
      if (!rows[k][40]) begin
        chk("o_io_rdata", q, rows[k][31:0]);
      end
    end
    acc(1'b1, 4'h3, 4'hf, 32'ha5);
    acc(1'b1, 4'h3, 4'hf, 32'hff);
    acc(1'b0, 4'h3, 4'hf, 32'h0);
    chk("o_io_rdata", q, 32'ha5);
    @(negedge i_mclk) ev = 32'h3;
    @(negedge i_mclk) ev = 32'h0;
    acc(1'b1, 4'h2, 4'hf, 32'h1);
    acc(1'b0, 4'h2, 4'hf, 32'h0);
    chk("o_io_rdata", q, 32'h2);
    host.io(1'b1, 16'h0cf8, 4'h3, 32'h0);
    host.io(1'b0, 16'h0cf8, 4'hf, 32'h0);
    chk("o_io_rdata", q, 32'h80000008);
    @(negedge i_mclk) soft_n = 0;
    @(negedge i_mclk) soft_n = 1;
    host.io(1'b0, 16'h0cfc, 4'hf, 32'h0);
    chk("o_io_rdata", q, 32'hffffffff);
    acc(1'b0, 4'h1, 4'hf, 32'h0);
    chk("o_io_rdata", q, 32'h0);
    acc(1'b0, 4'h4, 4'hf, 32'h0);
    chk("o_io_rdata", q, 32'h3);
    acc(1'b0, 4'h3, 4'hf, 32'h0);
    chk("o_io_rdata", q, 32'ha5);
    // Power-valid passes a pin filter: hold it low long enough, then let
    // the hard reset run out before the next access
    @(negedge i_mclk) pwr = 0;
    repeat (6) @(negedge i_mclk);
    pwr = 1;
    repeat (6) @(negedge i_mclk);
    acc(1'b0, 4'h4, 4'hf, 32'h0);
    chk("o_io_rdata", q, 32'h0);
    acc(1'b0, 4'h5, 4'hf, 32'h0);
    chk("o_io_rdata", q, 32'hc3);
    acc(1'b1, 4'h3, 4'hf, 32'h5a);
    acc(1'b0, 4'h3, 4'hf, 32'h0);
    chk("o_io_rdata", q, 32'h5a);
    report_and_stop;
  end
endmodule
